// file: include/fec_buf_pkg.sv
// shared constants and carrier types for the fec packet buffer engine
package fec_buf_pkg;
  localparam int          DW_BITS        = 64;
  localparam int          BURST_WORDS    = 16;
  localparam int          BURST_BYTES    = 128;
  localparam int          REGION_KBITS   = 128;
  localparam int          DEF_CHANNELS   = 8;
  localparam int          MAX_CHANNELS   = 8;
  localparam int          DEF_FEC_INC    = 1;
  localparam int          FIFO_WORDS     = 16;
  localparam logic [4:0]  FEC_ROW        = 5'h1f;
  localparam logic [4:0]  FEC_COL_MAX    = 5'h13;
  localparam logic [7:0]  STAT_SEL_OFS   = 8'hfc;
  localparam logic [7:0]  STAT_DATA_OFS  = 8'hfb;
  localparam logic [7:0]  ERR_HIGH_STAT  = 8'h0c;
  localparam logic [7:0]  ERR_MID_STAT   = 8'h0d;
  localparam logic [7:0]  ERR_LOW_STAT   = 8'h0e;
  localparam logic [7:0]  STAT_SEL_RST   = 8'h00;
  localparam logic [23:0] ERR_CNT_RST    = 24'h000000;

  typedef struct packed {
    logic [6:0] chan;
    logic       zero;
    logic [4:0] fec;
    logic [3:0] slot;
    logic [6:0] beat;
  } mem_addr_t;

  typedef struct packed {
    logic      rnw;
    mem_addr_t addr;
  } mem_cmd_t;

  typedef struct packed {
    logic [6:0]  chan;
    logic [4:0]  fec;
    logic [3:0]  slot;
    logic        last;
    logic [63:0] data;
  } pkt_word_t;

  typedef struct packed {
    logic [6:0] chan;
    logic [4:0] fec;
    logic [3:0] slot;
    logic [3:0] bursts_m1;
  } rd_req_t;
endpackage

// file: rtl/fec_buf_engine.sv
// fec packet buffer engine: packet fifo, burst mover, error statistic, loopback
//
// Contract
// - A 24-bit recovery error count reads as bytes 0x0c to 0x0e, high first, reset to zero.
// - Software writes the selector first, then reads the selected statistic byte.
// - The built channel count is a parameter from one to eight with a default of eight.
// - With the fec include parameter at zero no fec is made and no memory access is issued.
// - Each channel owns a fixed 128 Kb memory region for its stored fec packets.
// - Memory address bits 23:17 carry the channel and bit 16 is always zero.
// - Address bits 15:11 hold the fec type, 11111 for row, 00000 to 10011 for a column index.
// - Memory address bits 10:7 pick a 2KB packet slot holding one packet.
// - Memory address bits 6:0 address data within the slot, bits 6:3 picking one burst of sixteen 64-bit words.
// - Every memory read and write is a burst of exactly 128 bytes.
// - Whole packets with all their headers are written, not just the stream payload.
// - Row and column fec packets are both written to and read back from memory.
// - Loopback sends receive channel i out on transmit channel i+1, the last on the first.
`timescale 1ns/1ns

module fec_pkt_fifo #(
  parameter int WIDTH = 81,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  logic [AW:0]      fill_d;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  // ready is a flop: it is worked out from the fill level after this edge
  assign fill_d    = wr_q - rd_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= fill_d != (AW+1)'(DEPTH);
    end
  end
endmodule

module fec_buf_engine #(
  parameter int CHANNELS    = fec_buf_pkg::DEF_CHANNELS,
  parameter int FEC_INCLUDE = fec_buf_pkg::DEF_FEC_INC,
  parameter int FIFO_DEPTH  = fec_buf_pkg::FIFO_WORDS
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // byte register port
  input  wire logic                     reg_wr,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata_q,
  input  wire logic                     recov_err,
  // packet write stream
  input  wire fec_buf_pkg::pkt_word_t   pkt_word,
  input  wire logic                     pkt_valid,
  output logic                          pkt_ready,
  // packet read-back
  input  wire fec_buf_pkg::rd_req_t     rd_req,
  input  wire logic                     rd_req_valid,
  output logic                          rd_busy_q,
  output logic [63:0]                   rd_data_q,
  output logic                          rd_valid_q,
  output logic                          rd_last_q,
  // memory native port
  output fec_buf_pkg::mem_cmd_t         mem_cmd_q,
  output logic                          mem_req_q,
  input  wire logic                     mem_ack,
  output logic [63:0]                   mem_wr_data_q,
  output logic                          mem_wr_push_q,
  input  wire logic [63:0]              mem_rd_data,
  input  wire logic                     mem_rd_valid,
  // channel lanes
  input  wire logic                     loopback_en,
  input  wire logic [CHANNELS-1:0][7:0] rx_lane,
  input  wire logic [CHANNELS-1:0][7:0] tx_src,
  output logic [CHANNELS-1:0][7:0]      tx_lane_q
);
  localparam int         PW = $bits(fec_buf_pkg::pkt_word_t);
  localparam logic [3:0] LAST_BEAT = 4'(fec_buf_pkg::BURST_WORDS - 1);

  if (CHANNELS < 1 || CHANNELS > fec_buf_pkg::MAX_CHANNELS) begin : g_bad_ch
    $error("channel count must be 1 to 8");
  end
  if (FEC_INCLUDE < 0 || FEC_INCLUDE > 1) begin : g_bad_fec
    $error("fec include must be 0 or 1");
  end
  if (fec_buf_pkg::DW_BITS != 64) begin : g_bad_dw
    $error("memory data path must be 64 bits");
  end
  // sixteen 64-bit words per burst must add up to the 128-byte burst
  if (fec_buf_pkg::BURST_WORDS * fec_buf_pkg::DW_BITS / 8
      != fec_buf_pkg::BURST_BYTES) begin : g_bad_burst
    $error("burst must be 128 bytes");
  end
  // each channel owns every address below its channel field
  if ($bits(fec_buf_pkg::mem_addr_t) - 7
      != $clog2(fec_buf_pkg::REGION_KBITS * 1024)) begin : g_bad_region
    $error("channel region must span 128 K addresses");
  end

  typedef enum logic [2:0] {IDLE, WFILL, WADDR, RADDR, RDATA} mstate_t;
  mstate_t state_q;

  fec_buf_pkg::pkt_word_t fifo_word;
  logic [PW-1:0]          fifo_raw;
  logic                   fifo_valid;
  logic                   fifo_pop;
  logic                   fifo_in_ready;

  fec_pkt_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (pkt_word),
    .in_valid  (pkt_valid && FEC_INCLUDE != 0),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_raw),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  assign fifo_word = fec_buf_pkg::pkt_word_t'(fifo_raw);
  // with fec left out nothing is buffered, the stream is simply refused
  if (FEC_INCLUDE != 0) begin : g_ready_on
    assign pkt_ready = fifo_in_ready;
  end else begin : g_ready_off
    assign pkt_ready = 1'b0;
  end

  // ---------------- statistics ----------------
  logic [7:0]  stat_sel_q;
  logic [23:0] err_cnt_q;

  function automatic logic [7:0] stat_byte(input logic [7:0] sel, input logic [23:0] cnt);
    unique case (sel)
      fec_buf_pkg::ERR_HIGH_STAT: stat_byte = cnt[23:16];
      fec_buf_pkg::ERR_MID_STAT:  stat_byte = cnt[15:8];
      fec_buf_pkg::ERR_LOW_STAT:  stat_byte = cnt[7:0];
      default:                    stat_byte = 8'h00;
    endcase
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_sel_q <= fec_buf_pkg::STAT_SEL_RST;
    end else if (reg_wr && reg_addr == fec_buf_pkg::STAT_SEL_OFS) begin
      stat_sel_q <= reg_wdata;
    end
  end

  // saturates so a long error burst never wraps back to a small count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_cnt_q <= fec_buf_pkg::ERR_CNT_RST;
    end else if (recov_err && err_cnt_q != 24'hffffff) begin
      err_cnt_q <= err_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_addr == fec_buf_pkg::STAT_SEL_OFS) begin
      reg_rdata_q <= stat_sel_q;
    end else if (reg_addr == fec_buf_pkg::STAT_DATA_OFS) begin
      reg_rdata_q <= stat_byte(stat_sel_q, err_cnt_q);
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ---------------- burst mover ----------------
  logic [3:0]  beat_q;
  logic [3:0]  burst_q;
  logic [3:0]  bursts_m1_q;
  logic        pad_q;
  logic [6:0]  chan_q;
  logic [4:0]  fec_q;
  logic [3:0]  slot_q;
  logic        pkt_done;

  // a new packet starts on a header word; words are padded after last
  assign fifo_pop = state_q == WFILL && !pad_q && fifo_valid;
  assign pkt_done = pad_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= IDLE;
      beat_q      <= 4'h0;
      burst_q     <= 4'h0;
      bursts_m1_q <= 4'h0;
      pad_q       <= 1'b0;
      chan_q      <= 7'h00;
      fec_q       <= 5'h00;
      slot_q      <= 4'h0;
    end else begin
      unique case (state_q)
        IDLE: begin
          beat_q  <= 4'h0;
          burst_q <= 4'h0;
          pad_q   <= 1'b0;
          if (FEC_INCLUDE == 0) begin
            state_q <= IDLE;
          end else if (rd_req_valid) begin
            chan_q      <= rd_req.chan;
            fec_q       <= rd_req.fec;
            slot_q      <= rd_req.slot;
            bursts_m1_q <= rd_req.bursts_m1;
            state_q     <= RADDR;
          end else if (fifo_valid) begin
            chan_q  <= fifo_word.chan;
            fec_q   <= fifo_word.fec;
            slot_q  <= fifo_word.slot;
            state_q <= WFILL;
          end
        end
        WFILL: begin
          if (pad_q || fifo_valid) begin
            beat_q <= beat_q + 4'h1;
            if (fifo_pop && fifo_word.last) begin
              pad_q <= 1'b1;
            end
            if (beat_q == LAST_BEAT) begin
              state_q <= WADDR;
            end
          end
        end
        WADDR: begin
          if (mem_ack) begin
            burst_q <= burst_q + 4'h1;
            state_q <= pkt_done ? IDLE : WFILL;
          end
        end
        RADDR: begin
          if (mem_ack) begin
            beat_q  <= 4'h0;
            state_q <= RDATA;
          end
        end
        RDATA: begin
          if (mem_rd_valid) begin
            beat_q <= beat_q + 4'h1;
            if (beat_q == LAST_BEAT) begin
              burst_q <= burst_q + 4'h1;
              state_q <= burst_q == bursts_m1_q ? IDLE : RADDR;
            end
          end
        end
      endcase
    end
  end

  // write data goes in ahead of the address request, as the port expects
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wr_data_q <= 64'h0;
      mem_wr_push_q <= 1'b0;
    end else begin
      mem_wr_push_q <= state_q == WFILL && (pad_q || fifo_valid);
      mem_wr_data_q <= pad_q ? 64'h0 : fifo_word.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_req_q <= 1'b0;
      mem_cmd_q <= '0;
    end else begin
      mem_req_q <= FEC_INCLUDE != 0 && (state_q == WADDR || state_q == RADDR)
                   && !mem_ack;
      mem_cmd_q.rnw       <= state_q == RADDR;
      mem_cmd_q.addr.chan <= chan_q;
      mem_cmd_q.addr.zero <= 1'b0;
      mem_cmd_q.addr.fec  <= fec_q;
      mem_cmd_q.addr.slot <= slot_q;
      mem_cmd_q.addr.beat <= {burst_q, 3'b000};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q  <= 64'h0;
      rd_valid_q <= 1'b0;
      rd_last_q  <= 1'b0;
      rd_busy_q  <= 1'b0;
    end else begin
      rd_busy_q  <= state_q != IDLE;
      rd_valid_q <= state_q == RDATA && mem_rd_valid;
      rd_data_q  <= mem_rd_data;
      rd_last_q  <= state_q == RDATA && mem_rd_valid && beat_q == LAST_BEAT
                    && burst_q == bursts_m1_q;
    end
  end

  // ---------------- loopback ----------------
  for (genvar i = 0; i < CHANNELS; i++) begin : g_lane
    localparam int SRC = (i + CHANNELS - 1) % CHANNELS;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        tx_lane_q[i] <= 8'h00;
      end else begin
        tx_lane_q[i] <= loopback_en ? rx_lane[SRC] : tx_src[i];
      end
    end
  end
endmodule

// file: verif/fec_buf_engine_properties.sv
// assertions on the fec buffer engine ports
`timescale 1ns/1ns
module fec_buf_engine_properties #(
  parameter int CHANNELS    = 8,
  parameter int FEC_INCLUDE = 1
) (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  reg_wr,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata_q,
  input wire logic                  recov_err,
  input wire logic                  pkt_ready,
  input wire fec_buf_pkg::mem_cmd_t mem_cmd_q,
  input wire logic                  mem_req_q,
  input wire logic                  mem_ack,
  input wire logic                  mem_wr_push_q
);
  logic [7:0]  sel_q;
  logic [23:0] cnt_q;
  logic [4:0]  push_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shadow selector and count, so a byte read is tied to its cause
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_q <= 8'h00;
      cnt_q <= 24'h000000;
      push_q <= 5'h00;
    end else begin
      if (reg_wr && reg_addr == 8'hfc)
        sel_q <= reg_wdata;
      if (recov_err && cnt_q != 24'hffffff)
        cnt_q <= cnt_q + 24'h000001;
      if (mem_ack && !mem_cmd_q.rnw)
        push_q <= 5'h00;
      else if (mem_wr_push_q)
        push_q <= push_q + 5'h01;
    end
  end
  sequence s_wr_start;
    $rose(mem_req_q) && !mem_cmd_q.rnw;
  endsequence
  sequence s_wait;
    mem_req_q && !mem_ack;
  endsequence
  a_high_byte_read: assert property (
    reg_addr == 8'hfb && sel_q == 8'h0c |=> reg_rdata_q == $past(cnt_q[23:16]))
    else $error("high count byte wrong");
  a_low_byte_read: assert property (
    reg_addr == 8'hfb && sel_q == 8'h0e |=> reg_rdata_q == $past(cnt_q[7:0]))
    else $error("low count byte wrong");
  a_other_stat_zero: assert property (
    reg_addr == 8'hfb && !(sel_q inside {8'h0c, 8'h0d, 8'h0e}) |=> reg_rdata_q == 8'h00)
    else $error("unmapped statistic not zero");
  a_addr_fields: assert property (mem_req_q |-> !mem_cmd_q.addr.zero &&
    mem_cmd_q.addr.chan < CHANNELS && mem_cmd_q.addr.beat[2:0] == 3'h0)
    else $error("memory address field bad");
  a_fec_code_legal: assert property (mem_req_q |->
    mem_cmd_q.addr.fec == 5'h1f || mem_cmd_q.addr.fec <= 5'h13) else $error("fec code bad");
  a_write_sixteen: assert property (s_wr_start |-> push_q == 5'h10)
    else $error("write burst not sixteen words");
  a_req_holds: assert property (s_wait |=> mem_req_q && $stable(mem_cmd_q))
    else $error("request moved before ack");
  a_req_drops: assert property (mem_req_q && mem_ack |=> !mem_req_q)
    else $error("request kept after ack");
  a_fec_off_quiet: assert property (FEC_INCLUDE == 0 |->
    !mem_req_q && !mem_wr_push_q && !pkt_ready) else $error("memory used without fec");
endmodule
bind fec_buf_engine fec_buf_engine_properties #(
  .CHANNELS(CHANNELS), .FEC_INCLUDE(FEC_INCLUDE)
) fec_buf_engine_properties_inst (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .recov_err(recov_err),
  .pkt_ready(pkt_ready), .mem_cmd_q(mem_cmd_q), .mem_req_q(mem_req_q),
  .mem_ack(mem_ack), .mem_wr_push_q(mem_wr_push_q)
);

// file: verif/mem_ctrl_model.sv
// behavioural memory controller port: acks bursts, stores and replays words
`timescale 1ns/1ns
module mem_ctrl_model (
  input  wire logic                  ref_clk,
  input  wire logic [3:0]            ack_delay,
  input  wire fec_buf_pkg::mem_cmd_t mem_cmd_q,
  input  wire logic                  mem_req_q,
  input  wire logic [63:0]           mem_wr_data_q,
  input  wire logic                  mem_wr_push_q,
  output logic                       mem_ack,
  output logic [63:0]                mem_rd_data,
  output logic                       mem_rd_valid
);
  logic [63:0]           store [bit [27:0]];
  logic [63:0]           wq [$];
  fec_buf_pkg::mem_cmd_t cmd;
  initial begin
    mem_ack = 1'b0;
    mem_rd_valid = 1'b0;
    mem_rd_data = 64'h0;
    forever begin
      @(posedge ref_clk);
      if (mem_wr_push_q)
        wq.push_back(mem_wr_data_q);
      if (mem_req_q && !mem_ack) begin
        cmd = mem_cmd_q;
        repeat (ack_delay) @(posedge ref_clk);
        mem_ack <= 1'b1;
        @(posedge ref_clk);
        mem_ack <= 1'b0;
        for (int i = 0; i < 16; i++) begin
          if (cmd.rnw) begin
            mem_rd_valid <= 1'b1;
            mem_rd_data <= store[{cmd.addr, 4'(i)}];
            @(posedge ref_clk);
          end else if (wq.size() > 0)
            store[{cmd.addr, 4'(i)}] = wq.pop_front();
        end
        // released data line shows garbage, never the last word
        mem_rd_valid <= 1'b0;
        mem_rd_data <= ~mem_rd_data;
        if (!cmd.rnw && mem_wr_push_q)
          wq.push_back(mem_wr_data_q);
      end
    end
  end
endmodule

// file: verif/fec_buf_engine_tb_top.sv
// self-checking bench for the fec buffer engine
`timescale 1ns/1ns
module fec_buf_engine_tb_top;
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   reg_wr = 1'b0;
  logic [7:0]             reg_addr = 8'h00;
  logic [7:0]             reg_wdata = 8'h00;
  logic                   recov_err = 1'b0;
  fec_buf_pkg::pkt_word_t pkt_word = '0;
  logic                   pkt_valid = 1'b0;
  fec_buf_pkg::rd_req_t   rd_req = '0;
  logic                   rd_req_valid = 1'b0;
  logic                   loopback_en = 1'b0;
  logic [7:0][7:0]        rx_lane = '0;
  logic [7:0][7:0]        tx_src = '0;
  logic [3:0]             ack_delay = 4'h0;
  logic [7:0]             reg_rdata_q;
  logic                   pkt_ready, quiet_ready, rd_busy_q, rd_valid_q, rd_last_q;
  logic [63:0]            rd_data_q, mem_wr_data_q, mem_rd_data;
  fec_buf_pkg::mem_cmd_t  mem_cmd_q;
  logic                   mem_req_q, mem_ack, mem_wr_push_q, mem_rd_valid;
  logic [7:0][7:0]        tx_lane_q;
  int                     miscompares = 0;
  int                     comparisons = 0;
  int                     stalls = 0;
  always #10 ref_clk = ~ref_clk;
  fec_buf_engine fec_buf_engine_inst (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .recov_err(recov_err), .pkt_word(pkt_word), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .rd_req(rd_req), .rd_req_valid(rd_req_valid), .rd_busy_q(rd_busy_q), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_last_q(rd_last_q), .mem_cmd_q(mem_cmd_q), .mem_req_q(mem_req_q),
    .mem_ack(mem_ack), .mem_wr_data_q(mem_wr_data_q), .mem_wr_push_q(mem_wr_push_q),
    .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid), .loopback_en(loopback_en),
    .rx_lane(rx_lane), .tx_src(tx_src), .tx_lane_q(tx_lane_q));
  // one channel built without fec: must never touch memory
  fec_buf_engine #(.CHANNELS(1), .FEC_INCLUDE(0)) fec_buf_engine_inst_nofec (.ref_clk(ref_clk),
    .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(),
    .recov_err(recov_err), .pkt_word(pkt_word), .pkt_valid(pkt_valid), .pkt_ready(quiet_ready),
    .rd_req(rd_req), .rd_req_valid(rd_req_valid), .rd_busy_q(), .rd_data_q(), .rd_valid_q(),
    .rd_last_q(), .mem_cmd_q(), .mem_req_q(), .mem_ack(1'b0), .mem_wr_data_q(),
    .mem_wr_push_q(), .mem_rd_data(64'h0), .mem_rd_valid(1'b0), .loopback_en(loopback_en),
    .rx_lane(rx_lane[0:0]), .tx_src(tx_src[0:0]), .tx_lane_q());
  mem_ctrl_model mem_ctrl_model_inst (.ref_clk(ref_clk), .ack_delay(ack_delay),
    .mem_cmd_q(mem_cmd_q), .mem_req_q(mem_req_q), .mem_wr_data_q(mem_wr_data_q),
    .mem_wr_push_q(mem_wr_push_q), .mem_ack(mem_ack), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic stat_read(input logic [7:0] s, input logic [7:0] exp);
    reg_write(8'hfc, s);
    reg_addr = 8'hfb;
    @(negedge ref_clk);
    check(64'(reg_rdata_q), 64'(exp));
  endtask
  task automatic send_pkt(input logic [6:0] c, input logic [4:0] f, input logic [3:0] s, int n);
    for (int i = 0; i < n; i++) begin
      pkt_word = '{c, f, s, i == n - 1, {c, f, s, 48'(i)}};
      pkt_valid = 1'b1;
      for (int t = 0; t < 300 && pkt_ready !== 1'b1; t++) begin
        stalls++;
        @(negedge ref_clk);
      end
      @(negedge ref_clk);
    end
    pkt_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic read_pkt(input logic [6:0] c, input logic [4:0] f, input logic [3:0] s, int n);
    int k;
    int idle;
    k = 0;
    idle = 0;
    // the fifo must be drained so the request meets an idle engine
    for (int t = 0; t < 2000 && idle < 4; t++) begin
      @(negedge ref_clk);
      idle = (rd_busy_q === 1'b0) ? idle + 1 : 0;
    end
    check(64'(idle), 64'd4);
    rd_req = '{c, f, s, 4'h1};
    rd_req_valid = 1'b1;
    @(negedge ref_clk);
    rd_req_valid = 1'b0;
    for (int t = 0; t < 500 && k < 32; t++) begin
      @(negedge ref_clk);
      if (rd_valid_q === 1'b1) begin
        check(rd_data_q, k < n ? {c, f, s, 48'(k)} : 64'h0);
        check(64'(rd_last_q), 64'(k == 31));
        k++;
      end
      // k is 0 or 16 while a request stands; burst n starts at beat field 8n
      if (mem_req_q === 1'b1)
        check(64'(mem_cmd_q), 64'({1'b1, c, 1'b0, f, s, 7'(k / 2)}));
    end
    check(64'(k), 64'd32);
  endtask
  initial begin
    logic [7:0] sel [4] = '{8'h0c, 8'h0d, 8'h0e, 8'h0b};
    logic [7:0] val [4] = '{8'h00, 8'h01, 8'h2c, 8'h00};
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    stat_read(8'h0c, 8'h00);
    reg_write(8'h0e, 8'hff);
    recov_err = 1'b1;
    repeat (300) @(negedge ref_clk);
    recov_err = 1'b0;
    for (int i = 0; i < 4; i++)
      stat_read(sel[i], val[i]);
    reg_addr = 8'hfc;
    @(negedge ref_clk);
    check(64'(reg_rdata_q), 64'h0b);
    for (int i = 0; i < 8; i++) begin
      rx_lane[i] = 8'(8'h11 * i + 1);
      tx_src[i] = 8'(8'h80 + i);
    end
    for (int m = 1; m >= 0; m--) begin
      loopback_en = m[0];
      @(negedge ref_clk);
      for (int i = 0; i < 8; i++)
        check(64'(tx_lane_q[i]), 64'(m ? rx_lane[(i + 7) % 8] : tx_src[i]));
    end
    check(64'(quiet_ready), 64'h0);
    ack_delay = 4'hf;
    send_pkt(7'd7, fec_buf_pkg::FEC_ROW, 4'hf, 20);
    send_pkt(7'd0, fec_buf_pkg::FEC_COL_MAX, 4'h0, 17);
    check(64'(stalls > 0), 64'h1);
    ack_delay = 4'h5;
    read_pkt(7'd7, fec_buf_pkg::FEC_ROW, 4'hf, 20);
    ack_delay = 4'h0;
    read_pkt(7'd0, fec_buf_pkg::FEC_COL_MAX, 4'h0, 17);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
endmodule
